//--- core/timer_pkg.sv
package timer_pkg;

  localparam int NUM_CH = 3;
  localparam int CNT_W = 16;
  localparam int CFG_W = 8;
  localparam int DATA_W = 16;

  // Register selector values on the I/O request port
  localparam logic [1:0] REG_SETUP = 2'h0;
  localparam logic [1:0] REG_FLAGS = 2'h1;
  localparam logic [1:0] REG_TC = 2'h2;
  localparam logic [1:0] REG_COUNT = 2'h3;

  // channel_setup field positions
  localparam int SU_TRIG = 0;
  localparam int SU_GATE = 1;
  localparam int SU_CNTSEL = 2;
  localparam int SU_DRIVE = 3;
  localparam int SU_CONT = 4;
  localparam int SU_RETRIG = 5;
  localparam int SU_IRQ = 6;
  localparam int SU_CASCADE = 7;

  // channel_control_flags field positions
  localparam int FL_EN = 2;
  localparam int FL_GATE = 3;
  localparam int FL_TRIG = 4;
  localparam int FL_ACTIVE = 5;
  localparam int FL_DONE = 6;
  localparam int FL_OVR = 7;

  // Values after reset
  localparam logic [CFG_W-1:0] SETUP_RST = 8'h00;
  localparam logic [CNT_W-1:0] TC_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // Processor clock scaled by four for timing operation
  localparam int PRESCALE = 4;

  typedef struct packed {
    logic wr;
    logic [1:0] chan;
    logic [1:0] sel;
    logic [DATA_W-1:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic io_in;
    logic ct_in;
  } pin_in_t;

  typedef struct packed {
    logic io_out;
    logic io_oe;
  } pin_out_t;

  typedef struct packed {
    logic [CFG_W-1:0] setup;
    logic en;
    logic sgate;
    logic strig;
    logic cc;
    logic overrun_flag;
    logic active;
    logic triggered;
    logic halted;
    logic out;
    logic [CNT_W-1:0] tc;
    logic [CNT_W-1:0] cnt;
  } chan_t;

  typedef struct packed {
    chan_t [NUM_CH-1:0] ch;
    logic [DATA_W-1:0] rdata;
    logic [NUM_CH-1:0] irq;
    logic irq_any;
    logic [1:0] irq_top;
  } top_t;

  localparam chan_t CHAN_RST = '{
    setup: SETUP_RST, en: 1'h0, sgate: 1'h0, strig: 1'h0, cc: 1'h0,
    overrun_flag: 1'h0, active: 1'h0, triggered: 1'h0, halted: 1'h0,
    out: 1'h1, tc: TC_RST, cnt: CNT_RST};

  localparam top_t TOP_RST = '{
    ch: {NUM_CH{CHAN_RST}}, rdata: 16'h0000, irq: 3'h0,
    irq_any: 1'h0, irq_top: 2'h0};

endpackage

//--- core/pin_sync.sv
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
    logic rise;
  } sync_t;

  sync_t state_reg;
  sync_t state_next;

  // Stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
  always_comb begin
    state_next = state_reg;
    state_next.stage = {state_reg.stage[1:0], pin};
    state_next.rise = 1'h0;
    if (state_reg.stage[2] == state_reg.stage[1]) begin
      state_next.level = state_reg.stage[2];
      state_next.rise = state_reg.stage[2] & ~state_reg.level;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.level;
  assign rise = state_reg.rise;

endmodule

//--- core/clock_scaler.sv
module clock_scaler #(
  parameter int DIV = timer_pkg::PRESCALE
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);

  localparam int W = $clog2(DIV);

  typedef struct packed {
    logic [W-1:0] phase;
    logic tick;
  } scale_t;

  scale_t state_reg;
  scale_t state_next;

  // One pulse per rising edge of the scaled clock
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'h0;
    if (state_reg.phase == W'(DIV - 1)) begin
      state_next.phase = '0;
      state_next.tick = 1'h1;
    end else begin
      state_next.phase = state_reg.phase + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule

//--- core/timer_channels.sv
module timer_channels #(
  parameter int PRESCALE = timer_pkg::PRESCALE
) (
  input wire logic clk,
  input wire logic rst,
  input timer_pkg::io_req_t io_req,
  output logic [timer_pkg::DATA_W-1:0] io_rdata,
  input timer_pkg::pin_in_t [timer_pkg::NUM_CH-1:0] pins_in,
  output timer_pkg::pin_out_t [timer_pkg::NUM_CH-1:0] pins_out,
  input wire logic [timer_pkg::NUM_CH-1:0] irq_inhibit,
  output logic [timer_pkg::NUM_CH-1:0] irq_req,
  output logic irq_any,
  output logic [1:0] irq_top
);

  localparam int N = timer_pkg::NUM_CH;
  localparam int CW = timer_pkg::CNT_W;

  typedef struct packed {
    logic reserved;
    logic counter;
    logic gate_en;
    logic trig_en;
    logic drive;
    logic gate_lvl;
    logic trig_rise;
    logic event_rise;
  } roles_t;

  timer_pkg::top_t st_reg;
  timer_pkg::top_t st_next;

  logic [N-1:0] io_lvl;
  logic [N-1:0] io_rise;
  logic [N-1:0] in_lvl;
  logic [N-1:0] in_rise;
  logic tick;

  // Pin roles from the four-bit pin-function field
  function automatic roles_t pin_roles(
    input logic [3:0] f,
    input logic io_l,
    input logic io_r,
    input logic in_l,
    input logic in_r
  );
    roles_t r;
    r.drive = f[timer_pkg::SU_DRIVE];
    r.counter = f[timer_pkg::SU_CNTSEL];
    r.reserved = r.drive & r.counter
      & (f[timer_pkg::SU_GATE] | f[timer_pkg::SU_TRIG]);
    r.gate_en = f[timer_pkg::SU_GATE] & ~r.reserved;
    r.trig_en = f[timer_pkg::SU_TRIG] & ~r.reserved;
    r.event_rise = in_r;
    if (!r.drive) begin
      r.gate_lvl = io_l;
      r.trig_rise = r.counter ? io_r : in_r;
    end else begin
      r.gate_lvl = in_l;
      r.trig_rise = in_r;
    end
    return r;
  endfunction

  // Read image of channel_control_flags
  function automatic logic [timer_pkg::CFG_W-1:0] flags_of(
    input timer_pkg::chan_t c
  );
    logic [timer_pkg::CFG_W-1:0] v;
    v = '0;
    v[timer_pkg::FL_EN] = c.en;
    v[timer_pkg::FL_GATE] = c.sgate;
    v[timer_pkg::FL_TRIG] = c.strig;
    v[timer_pkg::FL_ACTIVE] = c.active;
    v[timer_pkg::FL_DONE] = c.cc;
    v[timer_pkg::FL_OVR] = c.overrun_flag;
    return v;
  endfunction

  // Lowest-numbered pending channel wins
  function automatic logic [1:0] top_of(input logic [N-1:0] pend);
    logic [1:0] w;
    w = 2'h0;
    for (int k = N - 1; k >= 0; k--) begin
      if (pend[k]) begin
        w = 2'(k);
      end
    end
    return w;
  endfunction

  clock_scaler #(
    .DIV(PRESCALE)
  ) u_scaler (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  generate
    for (genvar g = 0; g < N; g++) begin : g_sync
      // Both pins pass the synchroniser before any edge logic
      pin_sync u_io (
        .clk(clk),
        .rst(rst),
        .pin(pins_in[g].io_in),
        .level(io_lvl[g]),
        .rise(io_rise[g])
      );
      pin_sync u_in (
        .clk(clk),
        .rst(rst),
        .pin(pins_in[g].ct_in),
        .level(in_lvl[g]),
        .rise(in_rise[g])
      );
    end
  endgenerate

  always_comb begin
    logic [N-1:0] hit;
    logic [N-1:0] pend;
    roles_t r;
    timer_pkg::chan_t c;
    timer_pkg::chan_t n;
    logic sel;
    logic wr_setup;
    logic wr_flags;
    logic wr_tc;
    logic sw_trig;
    logic casc;
    logic en_eff;
    logic cont_eff;
    logic re_eff;
    logic gate_ok;
    logic armed;
    logic run;
    logic step;
    logic trig_ev;
    logic [timer_pkg::DATA_W-1:0] wd;
    timer_pkg::chan_t rc;
    hit = '0;
    pend = '0;
    r = '0;
    c = '0;
    n = '0;
    sel = 1'h0;
    wr_setup = 1'h0;
    wr_flags = 1'h0;
    wr_tc = 1'h0;
    sw_trig = 1'h0;
    casc = 1'h0;
    en_eff = 1'h0;
    cont_eff = 1'h0;
    re_eff = 1'h0;
    gate_ok = 1'h0;
    armed = 1'h0;
    run = 1'h0;
    step = 1'h0;
    trig_ev = 1'h0;
    wd = io_req.wdata;
    rc = '0;
    st_next = st_reg;

    // Channel 2 first, counting down, so channel 1's terminal count can feed channel 0
    for (int i = N - 1; i >= 0; i--) begin
      c = st_reg.ch[i];
      n = c;
      r = pin_roles(c.setup[3:0], io_lvl[i], io_rise[i],
        in_lvl[i], in_rise[i]);
      sel = io_req.wr && (io_req.chan == 2'(i));
      wr_setup = sel && (io_req.sel == timer_pkg::REG_SETUP);
      wr_flags = sel && (io_req.sel == timer_pkg::REG_FLAGS);
      wr_tc = sel && (io_req.sel == timer_pkg::REG_TC);

      // Only channel 0 honours the cascade bit
      casc = (i == 0) && c.setup[timer_pkg::SU_CASCADE];
      en_eff = casc ? st_reg.ch[1].en : c.en;
      cont_eff = casc ? st_reg.ch[1].setup[timer_pkg::SU_CONT]
        : c.setup[timer_pkg::SU_CONT];
      re_eff = casc ? 1'h0 : c.setup[timer_pkg::SU_RETRIG];
      if (casc) begin
        r.gate_en = 1'h0;
        r.trig_en = 1'h0;
        r.reserved = 1'h0;
      end

      // Software writes to the byte and word registers
      if (wr_setup) begin
        n.setup = wd[timer_pkg::CFG_W-1:0];
      end
      if (wr_tc) begin
        n.tc = wd;
      end
      sw_trig = wr_flags & wd[timer_pkg::FL_TRIG] & ~c.strig;
      if (wr_flags) begin
        n.en = wd[timer_pkg::FL_EN];
        n.sgate = wd[timer_pkg::FL_GATE];
        n.strig = wd[timer_pkg::FL_TRIG];
        n.cc = wd[timer_pkg::FL_DONE];
        n.overrun_flag = wd[timer_pkg::FL_OVR];
      end

      // Enabling conditions
      gate_ok = ~r.gate_en | (c.sgate & r.gate_lvl);
      armed = ~r.trig_en | (c.triggered & ~c.halted);
      run = en_eff & armed & gate_ok & ~c.halted & ~r.reserved;
      if (casc) begin
        step = run & hit[1];
      end else if (r.counter) begin
        step = run & r.event_rise;
      end else begin
        step = run & tick;
      end
      trig_ev = r.trig_en & en_eff
        & (r.trig_rise | (sw_trig & c.en));

      if (!en_eff) begin
        n.cnt = c.tc;
        n.triggered = 1'h0;
        n.halted = 1'h0;
      end else if (trig_ev && (!c.triggered || c.halted)) begin
        n.cnt = c.tc;
        n.triggered = 1'h1;
        n.halted = 1'h0;
      end else if (trig_ev) begin
        if (re_eff) begin
          n.cnt = c.tc;
        end
      end else if (step) begin
        if (c.cnt <= CW'(1)) begin
          hit[i] = 1'h1;
          if (cont_eff) begin
            n.cnt = c.tc;
          end else begin
            n.cnt = '0;
            n.halted = 1'h1;
          end
        end else begin
          n.cnt = c.cnt - CW'(1);
        end
      end

      // Hardware set wins over a software clear
      if (hit[i]) begin
        n.cc = 1'h1;
        if (c.cc) begin
          n.overrun_flag = 1'h1;
        end
      end

      // Active flag follows hardware only
      n.active = run & (n.cnt != '0) & ~n.halted;
      n.out = (n.cnt == '0) | hit[i];

      pend[i] = n.cc & c.setup[timer_pkg::SU_IRQ]
        & ~irq_inhibit[i];
      st_next.ch[i] = n;
    end

    st_next.irq = pend;
    st_next.irq_any = |pend;
    st_next.irq_top = top_of(pend);

    // Registered read data, one cycle after the request
    // Channel pick never indexes past the last channel
    for (int i = 0; i < N; i++) begin
      if (io_req.chan == 2'(i)) begin
        rc = st_reg.ch[i];
      end
    end
    case (io_req.sel)
      timer_pkg::REG_SETUP: begin
        st_next.rdata = {8'h00, rc.setup};
      end
      timer_pkg::REG_FLAGS: begin
        st_next.rdata = {8'h00, flags_of(rc)};
      end
      timer_pkg::REG_TC: begin
        st_next.rdata = rc.tc;
      end
      timer_pkg::REG_COUNT: begin
        st_next.rdata = rc.cnt;
      end
      default: begin
        st_next.rdata = '0;
      end
    endcase
    if (io_req.chan >= 2'(N)) begin
      st_next.rdata = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= timer_pkg::TOP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  generate
    for (genvar g = 0; g < N; g++) begin : g_out
      // Output drive claims the two-way pin unless counter select and gate or trigger are also set
      assign pins_out[g].io_out = st_reg.ch[g].out;
      assign pins_out[g].io_oe = st_reg.ch[g].setup[timer_pkg::SU_DRIVE]
        & ~(st_reg.ch[g].setup[timer_pkg::SU_CNTSEL]
        & (st_reg.ch[g].setup[timer_pkg::SU_GATE]
        | st_reg.ch[g].setup[timer_pkg::SU_TRIG]));
    end
  endgenerate

  assign io_rdata = st_reg.rdata;
  assign irq_req = st_reg.irq;
  assign irq_any = st_reg.irq_any;
  assign irq_top = st_reg.irq_top;

endmodule

//--- test/timer_chk.sv
module timer_chk #(
  parameter int PRESCALE = timer_pkg::PRESCALE
) (
  input wire logic clk,
  input wire logic rst,
  input timer_pkg::io_req_t io_req,
  input wire logic [timer_pkg::DATA_W-1:0] io_rdata,
  input timer_pkg::pin_in_t [timer_pkg::NUM_CH-1:0] pins_in,
  input timer_pkg::pin_out_t [timer_pkg::NUM_CH-1:0] pins_out,
  input wire logic [timer_pkg::NUM_CH-1:0] irq_inhibit,
  input wire logic [timer_pkg::NUM_CH-1:0] irq_req,
  input wire logic irq_any,
  input wire logic [1:0] irq_top
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_hold;
    !io_req.wr && $stable(io_req.chan) && $stable(io_req.sel);
  endsequence
  sequence s_tc_wr;
    io_req.wr && io_req.sel == timer_pkg::REG_TC && io_req.chan != 2'h3;
  endsequence
  sequence s_off_wr;
    io_req.wr && io_req.sel == timer_pkg::REG_FLAGS &&
      io_req.chan != 2'h3 && !io_req.wdata[timer_pkg::FL_EN];
  endsequence
  sequence s_undriven_wr;
    io_req.wr && io_req.sel == timer_pkg::REG_SETUP && io_req.chan != 2'h3
      && (!io_req.wdata[3] || io_req.wdata[2] && io_req.wdata[1:0] != 2'h0);
  endsequence
  sequence s_irq_off_wr;
    io_req.wr && io_req.sel == timer_pkg::REG_SETUP && io_req.chan != 2'h3
      && !io_req.wdata[timer_pkg::SU_IRQ];
  endsequence

  a_tc_readback: assert property (s_tc_wr ##1 s_hold
    |=> io_rdata == $past(io_req.wdata, 2))
    else $error("time constant readback differs");
  a_unmapped_zero: assert property (io_req.chan == 2'h3
    |=> io_rdata == 16'h0000) else $error("unmapped read not zero");
  a_off_idle: assert property (s_off_wr ##1 s_hold [*2]
    |=> !io_rdata[timer_pkg::FL_ACTIVE] && !io_rdata[timer_pkg::FL_EN])
    else $error("disabled channel shows activity");
  a_oe_field: assert property (s_undriven_wr
    |=> !pins_out[$past(io_req.chan)].io_oe)
    else $error("pin driven without output drive");
  a_reset_state: assert property ($fell(rst) |-> io_rdata == 16'h0000
    && irq_req == 3'h0 && pins_out[0].io_out && !pins_out[0].io_oe)
    else $error("state after reset wrong");
  a_any_pending: assert property (irq_any == |irq_req)
    else $error("summary request mismatch");
  a_top_prio: assert property (irq_top == (irq_req[0] ? 2'h0 :
    irq_req[1] ? 2'h1 : irq_req[2] ? 2'h2 : 2'h0))
    else $error("priority index wrong");
  a_inhibit_mask: assert property (|irq_inhibit
    |=> (irq_req & $past(irq_inhibit)) == 3'h0)
    else $error("inhibited request raised");
  a_irq_gate: assert property (s_irq_off_wr |-> ##2
    !irq_req[$past(io_req.chan, 2)]) else $error("request without enable");
endmodule

bind timer_channels timer_chk #(.PRESCALE(PRESCALE)) u_chk (.clk(clk),
  .rst(rst), .io_req(io_req), .io_rdata(io_rdata), .pins_in(pins_in),
  .pins_out(pins_out), .irq_inhibit(irq_inhibit), .irq_req(irq_req),
  .irq_any(irq_any), .irq_top(irq_top));

//--- test/ext_source.sv
module ext_source (
  input wire logic clk,
  input wire logic [2:0] io_lvl,
  input wire logic [2:0] ev_go,
  input timer_pkg::pin_out_t [2:0] pins_out,
  output timer_pkg::pin_in_t [2:0] pins_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph [3] = '{default: 3'h0};

  // Each request gives one event: four cycles high, then low
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (ev_go[i] && ph[i] == 3'h0) ph[i] <= 3'h7;
      else if (ph[i] != 3'h0) ph[i] <= ph[i] - 3'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pins_in[i].ct_in = ph[i] >= 3'h4;
      pins_in[i].io_in = pins_out[i].io_oe ? pins_out[i].io_out : io_lvl[i];
    end
  end
endmodule

//--- test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  timer_pkg::io_req_t io_req = '0;
  logic [15:0] io_rdata;
  timer_pkg::pin_in_t [2:0] pins_in;
  timer_pkg::pin_out_t [2:0] pins_out;
  logic [2:0] irq_inhibit = 3'h0;
  logic [2:0] irq_req;
  logic irq_any;
  logic [1:0] irq_top;
  logic [2:0] io_lvl = 3'h0;
  logic [2:0] ev_go = 3'h0;
  logic [15:0] d;
  logic [15:0] e;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #4 clk = ~clk;

  timer_channels #(.PRESCALE(4)) u_dut (.clk(clk), .rst(rst),
    .io_req(io_req), .io_rdata(io_rdata), .pins_in(pins_in),
    .pins_out(pins_out), .irq_inhibit(irq_inhibit), .irq_req(irq_req),
    .irq_any(irq_any), .irq_top(irq_top));
  ext_source u_src (.clk(clk), .io_lvl(io_lvl), .ev_go(ev_go),
    .pins_out(pins_out), .pins_in(pins_in));

  task automatic wr(input logic [1:0] ch, input logic [1:0] s,
                    input logic [15:0] v);
    @(posedge clk) io_req <= '{1'b1, ch, s, v};
    @(posedge clk) io_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] ch, input logic [1:0] s);
    @(posedge clk) io_req <= '{1'b0, ch, s, io_req.wdata};
    @(posedge clk);
    @(posedge clk);
    #1 d = io_rdata;
  endtask

  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic poll(input logic [1:0] ch, input int b);
    for (int i = 0; i < 40; i++) begin
      rd(ch, timer_pkg::REG_FLAGS);
      if (d[b] === 1'b1) break;
    end
    chk("flag wait", 16'h1, 16'(d[b]));
  endtask

  task automatic ev(input int ch);
    @(posedge clk) ev_go[ch] <= 1'b1;
    @(posedge clk) ev_go[ch] <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(2'h0, timer_pkg::REG_TC, 16'h0003);
    wr(2'h3, timer_pkg::REG_TC, 16'hFFFF);
    rd(2'h3, timer_pkg::REG_TC);
    chk("unmapped", 16'h0000, d);
    wr(2'h0, timer_pkg::REG_COUNT, 16'h0009);
    rd(2'h0, timer_pkg::REG_COUNT);
    chk("count copy", 16'h0003, d);
    wr(2'h0, timer_pkg::REG_SETUP, 16'h0040);
    rd(2'h0, timer_pkg::REG_SETUP);
    chk("setup", 16'h0040, d);
    wr(2'h0, timer_pkg::REG_FLAGS, 16'h0004);
    poll(2'h0, timer_pkg::FL_DONE);
    rd(2'h0, timer_pkg::REG_COUNT);
    chk("single stop", 16'h0000, d);
    chk("zero output", 16'h1, 16'(pins_out[0].io_out));
    // Continuous channel, done flag left set to provoke overrun
    wr(2'h1, timer_pkg::REG_TC, 16'h0002);
    wr(2'h1, timer_pkg::REG_SETUP, 16'h0050);
    wr(2'h1, timer_pkg::REG_FLAGS, 16'h0004);
    poll(2'h1, timer_pkg::FL_OVR);
    rd(2'h1, timer_pkg::REG_COUNT);
    chk("reload", 16'h1, 16'(d != 16'h0000));
    chk("both pending", 16'h3, 16'(irq_req));
    @(posedge clk) irq_inhibit <= 3'h1;
    repeat (2) @(posedge clk);
    #1 chk("inhibited top", 16'h1, 16'(irq_top));
    @(posedge clk) irq_inhibit <= 3'h0;
    wr(2'h0, timer_pkg::REG_FLAGS, 16'h0024);
    rd(2'h0, timer_pkg::REG_FLAGS);
    chk("flags", 16'h0004, d);
    chk("irq cleared", 16'h0, 16'(irq_req[0]));
    wr(2'h1, timer_pkg::REG_FLAGS, 16'h0000);
    rd(2'h1, timer_pkg::REG_FLAGS);
    chk("disabled", 16'h0, 16'({d[5], d[2]}));
    // Disabled channel as a static output port
    wr(2'h1, timer_pkg::REG_SETUP, 16'h0008);
    #1 d = 16'({pins_out[1].io_oe, pins_out[1].io_out});
    chk("port low", 16'h0002, d);
    wr(2'h1, timer_pkg::REG_TC, 16'h0000);
    repeat (2) @(posedge clk);
    #1 d = 16'({pins_out[1].io_oe, pins_out[1].io_out});
    chk("static port", 16'h0003, d);
    // Gated event counting on channel 2
    wr(2'h2, timer_pkg::REG_TC, 16'h0005);
    wr(2'h2, timer_pkg::REG_SETUP, 16'h0006);
    @(posedge clk) io_lvl <= 3'h4;
    wr(2'h2, timer_pkg::REG_FLAGS, 16'h0004);
    ev(2);
    rd(2'h2, timer_pkg::REG_COUNT);
    chk("soft gate off", 16'h0005, d);
    @(posedge clk) io_lvl <= 3'h0;
    wr(2'h2, timer_pkg::REG_FLAGS, 16'h000C);
    ev(2);
    rd(2'h2, timer_pkg::REG_COUNT);
    chk("gate low", 16'h0005, d);
    @(posedge clk) io_lvl <= 3'h4;
    repeat (5) @(posedge clk);
    ev(2);
    ev(2);
    rd(2'h2, timer_pkg::REG_COUNT);
    chk("events", 16'h0003, d);
    wr(2'h2, timer_pkg::REG_FLAGS, 16'h0004);
    ev(2);
    rd(2'h2, timer_pkg::REG_COUNT);
    chk("gate cleared", 16'h0003, d);
    // Triggered timing on channel 2
    wr(2'h2, timer_pkg::REG_FLAGS, 16'h0000);
    wr(2'h2, timer_pkg::REG_TC, 16'h0064);
    wr(2'h2, timer_pkg::REG_SETUP, 16'h0001);
    wr(2'h2, timer_pkg::REG_FLAGS, 16'h0004);
    repeat (20) @(posedge clk);
    rd(2'h2, timer_pkg::REG_COUNT);
    chk("untriggered", 16'h0064, d);
    wr(2'h2, timer_pkg::REG_FLAGS, 16'h0014);
    repeat (8) @(posedge clk);
    rd(2'h2, timer_pkg::REG_COUNT);
    e = d;
    chk("soft trigger", 16'h1, 16'(e < 16'h0064));
    repeat (37) @(posedge clk);
    rd(2'h2, timer_pkg::REG_COUNT);
    chk("tick rate", 16'h000A, e - d);
    // Hardware trigger edge while counting down
    ev(2);
    rd(2'h2, timer_pkg::REG_COUNT);
    chk("no retrigger", 16'h1, 16'(d < 16'h005F));
    wr(2'h2, timer_pkg::REG_SETUP, 16'h0021);
    ev(2);
    rd(2'h2, timer_pkg::REG_COUNT);
    chk("retrigger", 16'h1, 16'(d > 16'h005F));
    // Mid-run reset clears the enable
    @(posedge clk) rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(2'h2, timer_pkg::REG_FLAGS);
    chk("reset enable", 16'h0000, d);
    end_sim();
  end
endmodule
